// ===== dmpa_pkg.sv
// Operation
// [RULE1] Power loss in operation raises power alarm.
// [RULE2] Switch on without main power raises alarm.
// [RULE3] Alarms never force a link state change.
// [RULE4] Power alarm leaves status code zero.
// [RULE5] Power alarm keeps error indicator off.
// [RULE6] Enabling with both mode objects zero alarms.
// [RULE7] Unsupported operating mode write raises alarm.
// [RULE8] Full-closed accepts only position control modes.
// [RULE9] Standard two-degree type rejects 4, 10. The code rejects them only up to edition 2.
// [RULE10] Synchronisation type rejects modes 3, 9.
// [RULE11] Older editions: synchronisation type rejects 4, 10.
// [RULE12] Synchronisation type under full-closed raises alarm.
// [RULE13] Latched alarm flags with numbers until cleared.
package dmpa_pkg;

   // Register byte offsets on the Avalon-MM slave.
   localparam logic [4:0] OFS_STATUS = 5'h00;
   localparam logic [4:0] OFS_MASK = 5'h04;
   localparam logic [4:0] OFS_ABORT = 5'h08;
   localparam logic [4:0] OFS_CONFIG = 5'h0c;
   localparam logic [4:0] OFS_ALARM = 5'h10;
   localparam logic [4:0] OFS_OBSERVE = 5'h14;

   // Alarm bit positions in the status and mask registers.
   localparam int ALM_MPL = 0;
   localparam int ALM_CMS = 1;
   localparam int ALM_N = 2;

   // Configuration register fields.
   localparam int CFG_FC_BIT = 0;
   localparam int CFG_TDOF_EN_BIT = 1;
   localparam int CFG_TDOF_SYNC_BIT = 2;
   localparam int CFG_ED_LSB = 4;

   // Reset values.
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [15:0] ABORT_RST = 16'h0000;
   localparam logic [1:0] MASK_RST = 2'h0;

   // Abort option value that arms the power loss alarm.
   localparam logic [15:0] ABORT_ARM = 16'h0001;

   // Status code reported to the host by these alarms.
   localparam logic [15:0] AL_CODE_NONE = 16'h0000;

   // Alarm numbers reported with each latched flag.
   localparam logic [7:0] ALM_MAIN_NUM = 8'h58;
   localparam logic [7:0] ALM_SUB_MPL = 8'h00;
   localparam logic [7:0] ALM_SUB_CMS = 8'h01;

   // Error indicator pattern meaning off.
   localparam logic [1:0] LED_OFF = 2'h0;

   // Drive power state codes.
   localparam logic [2:0] PDS_READY = 3'h2;
   localparam logic [2:0] PDS_OP_EN = 3'h4;
   localparam logic [2:0] PDS_QSTOP = 3'h5;

   // Link state machine codes.
   localparam logic [3:0] ESM_PREOP = 4'h2;
   localparam logic [3:0] ESM_SAFEOP = 4'h4;
   localparam logic [3:0] ESM_OP = 4'h8;

   // Operating mode codes and edition limits.
   localparam logic [7:0] MODE_NONE = 8'h00;
   localparam logic [7:0] MODE_PV = 8'h03;
   localparam logic [7:0] MODE_TQ = 8'h04;
   localparam logic [7:0] MODE_CSV = 8'h09;
   localparam logic [7:0] MODE_CST = 8'h0a;
   localparam logic [3:0] ED_STD_MAX = 4'h2;
   localparam logic [3:0] ED_SYNC_TQ_MAX = 4'h4;

   // Bus slave states, Gray ordered.
   typedef enum logic [0:0] {
      AV_IDLE = 1'b0,
      AV_RESP = 1'b1
   } dmpa_av_st_t;

endpackage

// ===== dmpa_chk_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries mode writes and configuration to the mode checker.
interface dmpa_chk_if;
   logic mode_wr;         // One-cycle mode write strobe.
   logic [7:0] mode;      // Value being written.
   logic cfg_wr;          // One-cycle pulse after a config update.
   logic fc;              // Full-closed control selected.
   logic tdof_en;         // Two-degree control selected.
   logic tdof_sync;       // Synchronisation type when set.
   logic [3:0] edition;   // Function edition number.
   logic viol;            // One-cycle violation pulse.
   modport top (output mode_wr, mode, cfg_wr, fc, tdof_en, tdof_sync, edition, input viol);
   modport chk (input mode_wr, mode, cfg_wr, fc, tdof_en, tdof_sync, edition, output viol);
endinterface
`default_nettype wire

// ===== dmpa_mode_check.sv
`timescale 1ns/1ps
`default_nettype none
// Judges each mode write and each config update against the control setup.
module dmpa_mode_check #(
   parameter logic [15:0] SUPPORTED_MASK = 16'h07db,
   parameter logic [15:0] POSITION_MASK = 16'h01c2
) (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   dmpa_chk_if.chk chk
);

   // Registered state of the checker.
   typedef struct packed {
      logic viol;
   } dmpa_chk_state_t;

   dmpa_chk_state_t st_r;
   dmpa_chk_state_t st_nxt;
   logic in_table;  // Mode code falls inside the lookup range.
   logic supported; // Mode is one the drive offers.
   logic position;  // Mode is a position control mode.
   logic bad_mode;  // Mode write breaks some setup limit.
   logic bad_cfg;   // Configuration itself is illegal.

   // Evaluates the write against the mode tables and setup.
   always_comb begin
      in_table = (chk.mode[7:4] == 4'h0);
      supported = in_table && SUPPORTED_MASK[chk.mode[3:0]];
      position = in_table && POSITION_MASK[chk.mode[3:0]];
      bad_mode = 1'b0;
      if (!supported) begin
         bad_mode = 1'b1; // [RULE7]
      end
      if (chk.fc && !position && (chk.mode != dmpa_pkg::MODE_NONE)) begin
         bad_mode = 1'b1; // [RULE8]
      end
      if (chk.tdof_en && !chk.tdof_sync && (chk.edition <= dmpa_pkg::ED_STD_MAX) &&
          ((chk.mode == dmpa_pkg::MODE_TQ) || (chk.mode == dmpa_pkg::MODE_CST))) begin
         bad_mode = 1'b1; // [RULE9]
      end
      if (chk.tdof_en && chk.tdof_sync &&
          ((chk.mode == dmpa_pkg::MODE_PV) || (chk.mode == dmpa_pkg::MODE_CSV))) begin
         bad_mode = 1'b1; // [RULE10]
      end
      if (chk.tdof_en && chk.tdof_sync && (chk.edition <= dmpa_pkg::ED_SYNC_TQ_MAX) &&
          ((chk.mode == dmpa_pkg::MODE_TQ) || (chk.mode == dmpa_pkg::MODE_CST))) begin
         bad_mode = 1'b1; // [RULE11]
      end
      bad_cfg = chk.fc && chk.tdof_en && chk.tdof_sync; // [RULE12]
      st_nxt.viol = (chk.mode_wr && bad_mode) || (chk.cfg_wr && bad_cfg);
      if (i_srst) begin
         st_nxt.viol = 1'b0;
      end
   end

   // Registers the violation pulse.
   always_ff @(posedge i_clk_sys) begin
      st_r <= st_nxt;
   end

   assign chk.viol = st_r.viol;

endmodule
`default_nettype wire

// ===== dmpa_alarm_top.sv
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Power loss and control mode alarm detection with an Avalon-MM register slave.
module dmpa_alarm_top #(
   parameter logic [15:0] SUPPORTED_MASK = 16'h07db,
   parameter logic [15:0] POSITION_MASK = 16'h01c2
) (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_main_power_on,
   input wire logic [2:0] i_pds_state,
   input wire logic [3:0] i_esm_state,
   input wire logic i_switch_on_cmd,
   input wire logic i_mode_wr,
   input wire logic [7:0] i_mode_wr_data,
   input wire logic [7:0] i_mode_display,
   input wire logic [1:0] i_err_led_req,
   output logic [1:0] o_err_led,
   output logic [15:0] o_al_status_code,
   output logic o_esm_force_req,
   output logic o_main_power_loss_alarm,
   output logic o_control_mode_setting_alarm,
   output logic o_irq
);

   // Whole registered state of the block.
   typedef struct packed {
      dmpa_pkg::dmpa_av_st_t av_st;   // Bus slave phase.
      logic [31:0] rdata;             // Captured read data.
      logic [1:0] status;             // Sticky alarm flags.
      logic [1:0] mask;               // Interrupt enables.
      logic [15:0] abort_opt;         // Abort connection option code.
      logic [7:0] cfg;                // Control setup fields.
      logic cfg_wr;                   // Pulse after a config write.
      logic mode_wr;                  // Registered mode write strobe.
      logic [7:0] mode_obj;           // Last written operating mode.
      logic [2:0] pds_prev;           // Drive state one cycle ago.
      logic irq;                      // Interrupt level.
      logic [1:0] led;                // Error indicator pattern.
      logic [15:0] al_code;           // Status code toward the host.
      logic esm_force;                // Forced link transition request.
   } dmpa_top_state_t;

   dmpa_top_state_t st_r;
   dmpa_top_state_t st_nxt;
   logic bus_req;       // A read or write is presented.
   logic acc_done;      // The access completes at this edge.
   logic wr_done;       // A write completes at this edge.
   logic esm_live;      // Link is in a state where power loss counts.
   logic armed;         // Abort option arms the power loss alarm.
   logic mpl_run;       // Power lost while running.
   logic mpl_switch;    // Switch on refused for lack of power.
   logic cms_enable;    // Enabled with both mode objects zero.
   logic [1:0] alm_set; // Detection events this cycle.
   logic [1:0] alm_clr; // Write-one-to-clear requests this cycle.
   logic [31:0] rd_mux; // Read data selected by address.

   // Link toward the mode checker.
   dmpa_chk_if chk_if ();

   // Mode write and configuration go to the checker from registers.
   assign chk_if.mode_wr = st_r.mode_wr;
   assign chk_if.mode = st_r.mode_obj;
   assign chk_if.cfg_wr = st_r.cfg_wr;
   assign chk_if.fc = st_r.cfg[dmpa_pkg::CFG_FC_BIT];
   assign chk_if.tdof_en = st_r.cfg[dmpa_pkg::CFG_TDOF_EN_BIT];
   assign chk_if.tdof_sync = st_r.cfg[dmpa_pkg::CFG_TDOF_SYNC_BIT];
   assign chk_if.edition = st_r.cfg[dmpa_pkg::CFG_ED_LSB +: 4];

   // Mode checker instance.
   dmpa_mode_check #(
      .SUPPORTED_MASK(SUPPORTED_MASK),
      .POSITION_MASK(POSITION_MASK)
   ) u_chk (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .chk(chk_if.chk)
   );

   // Merges write data into a register under byte enables.
   function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // Bus handshake and detection terms.
   always_comb begin
      bus_req = i_avs_read || i_avs_write;
      acc_done = bus_req && (st_r.av_st == dmpa_pkg::AV_RESP);
      wr_done = acc_done && i_avs_write;
      esm_live = (i_esm_state == dmpa_pkg::ESM_PREOP) || (i_esm_state == dmpa_pkg::ESM_SAFEOP) ||
                 (i_esm_state == dmpa_pkg::ESM_OP);
      armed = (st_r.abort_opt == dmpa_pkg::ABORT_ARM);
      mpl_run = armed && !i_main_power_on && esm_live &&
                ((i_pds_state == dmpa_pkg::PDS_OP_EN) || (i_pds_state == dmpa_pkg::PDS_QSTOP)); // [RULE1]
      mpl_switch = armed && !i_main_power_on && esm_live && i_switch_on_cmd &&
                   (i_pds_state == dmpa_pkg::PDS_READY); // [RULE2]
      cms_enable = (i_pds_state == dmpa_pkg::PDS_OP_EN) && (st_r.pds_prev != dmpa_pkg::PDS_OP_EN) &&
                   (st_r.mode_obj == dmpa_pkg::MODE_NONE) &&
                   (i_mode_display == dmpa_pkg::MODE_NONE); // [RULE6]
      alm_set[dmpa_pkg::ALM_MPL] = mpl_run || mpl_switch;
      alm_set[dmpa_pkg::ALM_CMS] = cms_enable || chk_if.viol;
      alm_clr = '0;
      if (wr_done && (i_avs_address == dmpa_pkg::OFS_STATUS) && i_avs_byteenable[0]) begin
         alm_clr = i_avs_writedata[1:0];
      end
   end

   // Read data selection by address.
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (i_avs_address == dmpa_pkg::OFS_STATUS) begin
         rd_mux[1:0] = st_r.status;
      end else if (i_avs_address == dmpa_pkg::OFS_MASK) begin
         rd_mux[1:0] = st_r.mask;
      end else if (i_avs_address == dmpa_pkg::OFS_ABORT) begin
         rd_mux[15:0] = st_r.abort_opt;
      end else if (i_avs_address == dmpa_pkg::OFS_CONFIG) begin
         rd_mux[7:0] = st_r.cfg;
      end else if (i_avs_address == dmpa_pkg::OFS_ALARM) begin
         // Each latched alarm shows its main and sub number.
         if (st_r.status[dmpa_pkg::ALM_MPL]) begin
            rd_mux[15:0] = {dmpa_pkg::ALM_SUB_MPL, dmpa_pkg::ALM_MAIN_NUM}; // [RULE13]
         end
         if (st_r.status[dmpa_pkg::ALM_CMS]) begin
            rd_mux[31:16] = {dmpa_pkg::ALM_SUB_CMS, dmpa_pkg::ALM_MAIN_NUM}; // [RULE13]
         end
      end else if (i_avs_address == dmpa_pkg::OFS_OBSERVE) begin
         // Live view of the inputs the detectors use.
         rd_mux[2:0] = i_pds_state;
         rd_mux[7:4] = i_esm_state;
         rd_mux[8] = i_main_power_on;
         rd_mux[23:16] = st_r.mode_obj;
         rd_mux[31:24] = i_mode_display;
      end
   end

   // Next-state logic for the whole block.
   always_comb begin
      logic [31:0] merged;
      merged = 32'h0000_0000;
      st_nxt = st_r;
      st_nxt.cfg_wr = 1'b0;
      st_nxt.mode_wr = i_mode_wr;
      st_nxt.pds_prev = i_pds_state;
      // Bus slave phase: one wait cycle, then the access completes.
      case (st_r.av_st)
         dmpa_pkg::AV_IDLE: begin
            if (bus_req) begin
               st_nxt.av_st = dmpa_pkg::AV_RESP;
               st_nxt.rdata = i_avs_read ? rd_mux : 32'h0000_0000;
            end
         end
         dmpa_pkg::AV_RESP: begin
            st_nxt.av_st = dmpa_pkg::AV_IDLE;
         end
         default: begin
            st_nxt.av_st = dmpa_pkg::AV_IDLE;
         end
      endcase
      // Writes to the software registers.
      if (wr_done) begin
         if (i_avs_address == dmpa_pkg::OFS_MASK) begin
            merged = be_merge({30'h0, st_r.mask}, i_avs_writedata, i_avs_byteenable);
            st_nxt.mask = merged[1:0];
         end else if (i_avs_address == dmpa_pkg::OFS_ABORT) begin
            merged = be_merge({16'h0000, st_r.abort_opt}, i_avs_writedata, i_avs_byteenable);
            st_nxt.abort_opt = merged[15:0];
         end else if (i_avs_address == dmpa_pkg::OFS_CONFIG) begin
            merged = be_merge({24'h00_0000, st_r.cfg}, i_avs_writedata, i_avs_byteenable);
            st_nxt.cfg = merged[7:0];
            st_nxt.cfg_wr = i_avs_byteenable[0];
         end
      end
      // The mode object holds the host's latest operating mode.
      if (i_mode_wr) begin
         st_nxt.mode_obj = i_mode_wr_data;
      end
      // Sticky flags: a detection in the clearing cycle wins.
      for (int a = 0; a < dmpa_pkg::ALM_N; a++) begin
         st_nxt.status[a] = (st_r.status[a] && !alm_clr[a]) || alm_set[a]; // [RULE13]
      end
      st_nxt.irq = |(st_nxt.status & st_r.mask);
      // Alarms here never ask the link to change state.
      st_nxt.esm_force = 1'b0; // [RULE3]
      st_nxt.al_code = dmpa_pkg::AL_CODE_NONE; // [RULE4]
      // Indicator is forced off while the power alarm stands.
      if (st_nxt.status[dmpa_pkg::ALM_MPL]) begin
         st_nxt.led = dmpa_pkg::LED_OFF; // [RULE5]
      end else begin
         st_nxt.led = i_err_led_req;
      end
      // Synchronous reset returns everything to defaults.
      if (i_srst) begin
         st_nxt.av_st = dmpa_pkg::AV_IDLE;
         st_nxt.rdata = 32'h0000_0000;
         st_nxt.status = '0;
         st_nxt.mask = dmpa_pkg::MASK_RST;
         st_nxt.abort_opt = dmpa_pkg::ABORT_RST;
         st_nxt.cfg = dmpa_pkg::CFG_RST;
         st_nxt.cfg_wr = 1'b0;
         st_nxt.mode_wr = 1'b0;
         st_nxt.mode_obj = dmpa_pkg::MODE_NONE;
         st_nxt.pds_prev = 3'h0;
         st_nxt.irq = 1'b0;
         st_nxt.led = dmpa_pkg::LED_OFF;
      end
   end

   // Registers the whole state.
   always_ff @(posedge i_clk_sys) begin
      st_r <= st_nxt;
   end

   // Waitrequest falls only in the completion phase.
   assign o_avs_waitrequest = (st_r.av_st != dmpa_pkg::AV_RESP);
   assign o_avs_readdata = st_r.rdata;
   assign o_err_led = st_r.led;
   assign o_al_status_code = st_r.al_code;
   assign o_esm_force_req = st_r.esm_force;
   assign o_main_power_loss_alarm = st_r.status[dmpa_pkg::ALM_MPL];
   assign o_control_mode_setting_alarm = st_r.status[dmpa_pkg::ALM_CMS];
   assign o_irq = st_r.irq;

endmodule
`default_nettype wire

// ===== dmpa_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host controller model: drives drive states, link states and mode object traffic.
module dmpa_host_model (
   input wire logic i_clk_sys,
   output logic [2:0] o_pds_state,
   output logic [3:0] o_esm_state,
   output logic o_switch_on_cmd,
   output logic o_mode_wr,
   output logic [7:0] o_mode_wr_data,
   output logic [7:0] o_mode_display
);
   // Starts in Init with nothing requested.
   initial begin
      o_pds_state = 3'h1;
      o_esm_state = 4'h1;
      o_switch_on_cmd = 1'b0;
      o_mode_wr = 1'b0;
      o_mode_wr_data = 8'h00;
      o_mode_display = 8'h00;
   end
   // Moves drive state, link state and mode display at one edge.
   task automatic set_state(input logic [2:0] p, input logic [3:0] e, input logic [7:0] d);
      @(posedge i_clk_sys);
      o_pds_state <= p;
      o_esm_state <= e;
      o_mode_display <= d;
   endtask
   // Sends a one-cycle switch on command.
   task automatic switch_on();
      @(posedge i_clk_sys);
      o_switch_on_cmd <= 1'b1;
      @(posedge i_clk_sys);
      o_switch_on_cmd <= 1'b0;
   endtask
   // Writes the mode object; afterwards the data lines no longer hold the value.
   task automatic write_mode(input logic [7:0] m);
      @(posedge i_clk_sys);
      o_mode_wr <= 1'b1;
      o_mode_wr_data <= m;
      @(posedge i_clk_sys);
      o_mode_wr <= 1'b0;
      o_mode_wr_data <= ~m;
   endtask
endmodule
`default_nettype wire

// ===== dmpa_alarm_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the alarm block's ports: detection, latching and quiet reporting.
module dmpa_alarm_assertions #(
   parameter logic [15:0] SUPPORTED_MASK = 16'h07db
) (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic o_avs_waitrequest,
   input wire logic i_main_power_on,
   input wire logic [2:0] i_pds_state,
   input wire logic [3:0] i_esm_state,
   input wire logic i_switch_on_cmd,
   input wire logic i_mode_wr,
   input wire logic [7:0] i_mode_wr_data,
   input wire logic [7:0] i_mode_display,
   input wire logic [1:0] o_err_led,
   input wire logic [15:0] o_al_status_code,
   input wire logic o_esm_force_req,
   input wire logic o_main_power_loss_alarm,
   input wire logic o_control_mode_setting_alarm
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   logic [15:0] abort_r; // Shadow of the abort option code.
   logic [7:0] mode_r; // Shadow of the mode object.
   logic wr_done; // A bus write completes at this edge.
   logic armed; // Power alarm conditions apart from drive state.
   logic clr_st; // Write that clears status bits, lane 0 enabled.
   assign wr_done = i_avs_write && !o_avs_waitrequest;
   assign clr_st = wr_done && i_avs_address == dmpa_pkg::OFS_STATUS && i_avs_byteenable[0];
   assign armed = abort_r == dmpa_pkg::ABORT_ARM && !i_main_power_on &&
      (i_esm_state inside {dmpa_pkg::ESM_PREOP, dmpa_pkg::ESM_SAFEOP, dmpa_pkg::ESM_OP});
   // Shadows of the abort code, per byte lane, and of the mode object.
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         abort_r <= dmpa_pkg::ABORT_RST;
         mode_r <= dmpa_pkg::MODE_NONE;
      end else begin
         for (int b = 0; b < 2; b++) begin
            if (wr_done && i_avs_address == dmpa_pkg::OFS_ABORT && i_avs_byteenable[b]) begin
               abort_r[b*8 +: 8] <= i_avs_writedata[b*8 +: 8];
            end
         end
         if (i_mode_wr) begin
            mode_r <= i_mode_wr_data;
         end
      end
   end
   property p_loss_run;
      armed && (i_pds_state == dmpa_pkg::PDS_OP_EN || i_pds_state == dmpa_pkg::PDS_QSTOP) |=> o_main_power_loss_alarm;
   endproperty
   a_loss_run: assert property (p_loss_run) else $error("power loss in operation not flagged");
   property p_loss_switch;
      armed && i_pds_state == dmpa_pkg::PDS_READY && i_switch_on_cmd |=> o_main_power_loss_alarm;
   endproperty
   a_loss_switch: assert property (p_loss_switch) else $error("switch on without power not flagged");
   property p_no_force;
      $rose(o_main_power_loss_alarm || o_control_mode_setting_alarm) |-> !o_esm_force_req [*3];
   endproperty
   a_no_force: assert property (p_no_force) else $error("alarm forced a link transition");
   property p_code_zero;
      o_main_power_loss_alarm |-> o_al_status_code == dmpa_pkg::AL_CODE_NONE;
   endproperty
   a_code_zero: assert property (p_code_zero) else $error("status code not zero");
   property p_led_off;
      o_main_power_loss_alarm |-> o_err_led == dmpa_pkg::LED_OFF;
   endproperty
   a_led_off: assert property (p_led_off) else $error("indicator not off");
   property p_enable_zero;
      i_pds_state == dmpa_pkg::PDS_OP_EN && $past(i_pds_state) != dmpa_pkg::PDS_OP_EN && mode_r == 8'h00
         && i_mode_display == 8'h00 |-> ##[1:2] o_control_mode_setting_alarm;
   endproperty
   a_enable_zero: assert property (p_enable_zero) else $error("enable with zero modes not flagged");
   property p_mode_bad;
      i_mode_wr && (i_mode_wr_data > 8'h0f || !SUPPORTED_MASK[i_mode_wr_data[3:0]])
         |-> ##[1:3] o_control_mode_setting_alarm;
   endproperty
   a_mode_bad: assert property (p_mode_bad) else $error("unsupported mode not flagged");
   property p_hold_loss;
      o_main_power_loss_alarm && !(clr_st && i_avs_writedata[0]) |=> o_main_power_loss_alarm;
   endproperty
   a_hold_loss: assert property (p_hold_loss) else $error("power flag dropped without clear");
   property p_hold_mode;
      o_control_mode_setting_alarm && !(clr_st && i_avs_writedata[1]) |=> o_control_mode_setting_alarm;
   endproperty
   a_hold_mode: assert property (p_hold_mode) else $error("mode flag dropped without clear");
endmodule
bind dmpa_alarm_top dmpa_alarm_assertions #(.SUPPORTED_MASK(SUPPORTED_MASK)) i_dmpa_alarm_assertions (.i_clk_sys,
   .i_srst, .i_avs_address, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_waitrequest,
   .i_main_power_on, .i_pds_state, .i_esm_state, .i_switch_on_cmd, .i_mode_wr, .i_mode_wr_data, .i_mode_display,
   .o_err_led, .o_al_status_code, .o_esm_force_req, .o_main_power_loss_alarm, .o_control_mode_setting_alarm);
`default_nettype wire

// ===== dmpa_alarm_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Drives the alarm block through its register bus and a host model.
module dmpa_alarm_top_tb_top;
   localparam logic [4:0] ST = dmpa_pkg::OFS_STATUS; // Short register names.
   localparam logic [4:0] AB = dmpa_pkg::OFS_ABORT;
   localparam logic [4:0] CF = dmpa_pkg::OFS_CONFIG;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic [4:0] av_addr = 5'h00;
   logic av_rd = 1'b0;
   logic av_wr = 1'b0;
   logic [31:0] av_wd = 32'h0;
   logic [31:0] av_rdata;
   logic av_wait;
   logic power_on = 1'b1;
   logic [1:0] led_req = 2'h3;
   logic [2:0] pds;
   logic [3:0] esm;
   logic sw_on, mode_wr, force_req, mpl, cms, irq;
   logic [7:0] mode_data, mode_disp;
   logic [1:0] err_led;
   logic [15:0] al_code;
   int err_total = 0;
   int samples_checked = 0;
   // Mode table: config, mode, flag after config, flag after mode write.
   logic [7:0] t_cfg [11] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h22, 8'h32, 8'h56, 8'h56, 8'h46, 8'h07};
   logic [7:0] t_mode [11] = '{8'h02, 8'h10, 8'h06, 8'h03, 8'h08, 8'h04, 8'h0a, 8'h09, 8'h04, 8'h0a, 8'h08};
   logic [10:0] t_ec = 11'h400;
   logic [10:0] t_em = 11'h2ab;
   // Free-running 50 MHz clock.
   always #10 clk_sys = ~clk_sys;
   dmpa_alarm_top i_dmpa_alarm_top (.i_clk_sys(clk_sys), .i_srst(srst), .i_avs_address(av_addr),
      .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd), .i_avs_byteenable(4'hf),
      .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .i_main_power_on(power_on), .i_pds_state(pds),
      .i_esm_state(esm), .i_switch_on_cmd(sw_on), .i_mode_wr(mode_wr), .i_mode_wr_data(mode_data),
      .i_mode_display(mode_disp), .i_err_led_req(led_req), .o_err_led(err_led), .o_al_status_code(al_code),
      .o_esm_force_req(force_req), .o_main_power_loss_alarm(mpl), .o_control_mode_setting_alarm(cms), .o_irq(irq));
   dmpa_host_model i_dmpa_host_model (.i_clk_sys(clk_sys), .o_pds_state(pds), .o_esm_state(esm),
      .o_switch_on_cmd(sw_on), .o_mode_wr(mode_wr), .o_mode_wr_data(mode_data), .o_mode_display(mode_disp));
   // Compares one value and reports a mismatch at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One access, held until the rising edge at which waitrequest is sampled low.
   task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_sys);
      av_addr <= a;
      av_rd <= rd;
      av_wr <= !rd;
      av_wd <= d;
      do @(posedge clk_sys); while (av_wait !== 1'b0);
      q = av_rdata;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b0, a, d, q);
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b1, a, 32'h0, q);
      check(q, exp);
   endtask
   // Prints counts and the verdict, then stops.
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      wrap_up();
   end
   // Main sequence.
   initial begin
      repeat (10) @(posedge clk_sys);
      srst <= 1'b0;
      rd_chk(ST, 32'h0);
      rd_chk(AB, 32'h0);
      rd_chk(CF, 32'h0);
      rd_chk(5'h18, 32'h0);
      wr(AB, 32'h2);
      // A non-zero display keeps this enable from raising the mode alarm.
      i_dmpa_host_model.set_state(dmpa_pkg::PDS_OP_EN, dmpa_pkg::ESM_OP, 8'h01);
      power_on <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd_chk(ST, 32'h0);
      wr(AB, 32'h1);
      repeat (4) @(posedge clk_sys);
      rd_chk(ST, 32'h1);
      rd_chk(dmpa_pkg::OFS_ALARM, {16'h0, dmpa_pkg::ALM_SUB_MPL, dmpa_pkg::ALM_MAIN_NUM});
      check(32'(err_led), 32'(dmpa_pkg::LED_OFF));
      check(32'(al_code), 32'(dmpa_pkg::AL_CODE_NONE));
      check(32'(force_req), 32'h0);
      check(32'(irq), 32'h0);
      wr(dmpa_pkg::OFS_MASK, 32'h3);
      // The mask lands at the write's edge and the interrupt one edge later.
      repeat (2) @(posedge clk_sys);
      check(32'(irq), 32'h1);
      i_dmpa_host_model.set_state(dmpa_pkg::PDS_QSTOP, dmpa_pkg::ESM_SAFEOP, 8'h01);
      wr(ST, 32'h1);
      repeat (4) @(posedge clk_sys);
      rd_chk(ST, 32'h1);
      power_on <= 1'b1;
      wr(ST, 32'h1);
      rd_chk(ST, 32'h0);
      check(32'(irq), 32'h0);
      check(32'(err_led), 32'h3);
      i_dmpa_host_model.set_state(dmpa_pkg::PDS_READY, dmpa_pkg::ESM_PREOP, 8'h01);
      power_on <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd_chk(ST, 32'h0);
      i_dmpa_host_model.switch_on();
      repeat (3) @(posedge clk_sys);
      rd_chk(ST, 32'h1);
      power_on <= 1'b1;
      wr(ST, 32'h1);
      wr(AB, 32'h0);
      // Each configuration and mode write pair from the table.
      for (int k = 0; k < 11; k++) begin
         wr(CF, {24'h0, t_cfg[k]});
         repeat (3) @(posedge clk_sys);
         rd_chk(ST, {30'h0, t_ec[k], 1'b0});
         wr(ST, 32'h2);
         i_dmpa_host_model.write_mode(t_mode[k]);
         repeat (3) @(posedge clk_sys);
         rd_chk(ST, {30'h0, t_em[k], 1'b0});
         wr(ST, 32'h2);
      end
      i_dmpa_host_model.write_mode(8'h05);
      repeat (3) @(posedge clk_sys);
      rd_chk(dmpa_pkg::OFS_ALARM, {dmpa_pkg::ALM_SUB_CMS, dmpa_pkg::ALM_MAIN_NUM, 16'h0});
      check(32'(irq), 32'h1);
      wr(CF, 32'h0);
      wr(ST, 32'h2);
      // Enabling with a zero mode object alarms only when the display is zero too.
      i_dmpa_host_model.write_mode(dmpa_pkg::MODE_NONE);
      i_dmpa_host_model.set_state(dmpa_pkg::PDS_OP_EN, dmpa_pkg::ESM_OP, 8'h01);
      repeat (3) @(posedge clk_sys);
      rd_chk(ST, 32'h0);
      i_dmpa_host_model.set_state(dmpa_pkg::PDS_READY, dmpa_pkg::ESM_OP, 8'h00);
      i_dmpa_host_model.set_state(dmpa_pkg::PDS_OP_EN, dmpa_pkg::ESM_OP, 8'h00);
      repeat (3) @(posedge clk_sys);
      rd_chk(ST, 32'h2);
      check(32'({cms, mpl}), 32'h2);
      check(32'(force_req), 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
